//--- hdl/mq_pkg.sv
package mq_pkg;
    // ========================================
    // widths
    localparam int MQ_ADDR_W = 24;
    localparam int MQ_IDX_W = 16;
    localparam int MQ_TS_W = 16;
    // ========================================
    // status word fields
    localparam int MQ_NS_BIT = 15;
    localparam int MQ_PORT_BIT = 11;
    localparam int MQ_CH_LSB = 8;
    localparam int MQ_ODD_BIT = 3;
    localparam int MQ_ABT_BIT = 2;
    localparam int MQ_FST_BIT = 1;
    localparam int MQ_LST_BIT = 0;
    // odd, abort, first, last forced in the single-read protocol
    localparam logic [3:0] MQ_VSTAR_FLAGS = 4'hB;
    localparam logic [7:0] MQ_FILL_BYTE = 8'hFF;
    localparam logic [15:0] MQ_ZERO_WORD = 16'h0000;
    // ========================================
    // entry layout, in words
    localparam logic [1:0] MQ_OFF_STATUS = 2'h0;
    localparam logic [1:0] MQ_OFF_DATA = 2'h1;
    localparam logic [1:0] MQ_OFF_STAMP = 2'h2;
    localparam logic [1:0] MQ_OFF_ZERO = 2'h3;
    localparam int MQ_SHIFT_PLAIN = 1;
    localparam int MQ_SHIFT_STAMP = 2;
    // ========================================
    // reset values and stamp tick divider
    localparam logic [MQ_IDX_W-1:0] MQ_IDX_RESET = 16'h0000;
    localparam logic [MQ_TS_W-1:0] MQ_TS_RESET = 16'h0000;
    localparam int MQ_TICK_DIV = 1;

    typedef enum logic [2:0] {
        MQ_IDLE = 3'b000,
        MQ_READ = 3'b001,
        MQ_DATA = 3'b011,
        MQ_STAMP = 3'b010,
        MQ_ZERO = 3'b110,
        MQ_STATUS = 3'b111,
        MQ_OVF = 3'b101
    } mq_state_t;
endpackage

//--- hdl/mq_stamp_counter.sv
`timescale 1ns/1ns
`default_nettype none
module mq_stamp_counter #(
    parameter int TICK_DIV = mq_pkg::MQ_TICK_DIV
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // free-running time base
    output logic [mq_pkg::MQ_TS_W-1:0] stamp_o
);
    import mq_pkg::*;

    logic [15:0] div_cnt;
    wire tick = (div_cnt == 16'(TICK_DIV - 1));

    // ========================================
    // divider and binary counter
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_cnt <= 16'h0000;
            stamp_o <= MQ_TS_RESET;
        end else begin
            div_cnt <= tick ? 16'h0000 : div_cnt + 16'h0001;
            if (tick) begin
                stamp_o <= stamp_o + 16'h0001;
            end
        end
    end
endmodule
`default_nettype wire

//--- hdl/mq_byte_pair.sv
`timescale 1ns/1ns
`default_nettype none
module mq_byte_pair (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // mode
    input wire logic vstar_mode_i,
    input wire logic timestamp_enable_i,
    // raw monitor stream, one sample per frame
    input wire logic raw_valid_i,
    input wire logic [7:0] raw_byte_i,
    input wire logic eom_i,
    input wire logic abort_i,
    // assembled event
    input wire logic evt_ready_i,
    output logic evt_valid_o,
    output logic [7:0] first_monitor_byte_o,
    output logic [7:0] second_monitor_byte_o,
    output logic [3:0] evt_flags_o
);
    import mq_pkg::*;

    logic [7:0] prev_raw;
    logic have_prev, taken, in_msg, first_pend;
    logic [1:0] cnt;
    logic [7:0] lo, hi;

    // ========================================
    // acceptance: twice in a row in GCI, once in V*
    wire same = have_prev && (raw_byte_i == prev_raw);
    wire acc = raw_valid_i && (vstar_mode_i || (same && !taken));
    wire fire_end = (eom_i || abort_i) && !vstar_mode_i;
    wire pair_now = acc && !vstar_mode_i && ((cnt == 2'd1 && !timestamp_enable_i) || cnt == 2'd2);
    wire emit = fire_end || (acc && vstar_mode_i) || (acc && !fire_end && pair_now);
    wire slot_free = !evt_valid_o || evt_ready_i;
    // a second emit while the first is still unread is dropped; frame rate keeps it rare
    wire load = emit && slot_free;
    wire [7:0] end_hi = (cnt == 2'd2) ? hi : MQ_FILL_BYTE;
    wire [3:0] end_flags = {cnt == 2'd1, abort_i, first_pend && cnt != 2'd0, !abort_i}; // RULE7 RULE9 RULE16
    wire [7:0] pair_hi = (cnt == 2'd2) ? hi : raw_byte_i;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prev_raw <= 8'h00;
            have_prev <= 1'b0;
            taken <= 1'b0;
        end else if (raw_valid_i) begin
            prev_raw <= raw_byte_i;
            have_prev <= 1'b1;
            taken <= same && (taken || acc);
        end
    end

    // ========================================
    // pairing of accepted bytes into words
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt <= 2'd0;
            lo <= 8'h00;
            hi <= 8'h00;
            in_msg <= 1'b0;
            first_pend <= 1'b0;
        end else if (fire_end) begin
            cnt <= 2'd0;
            in_msg <= 1'b0;
        end else if (acc && !vstar_mode_i) begin
            if (cnt == 2'd0) begin
                lo <= raw_byte_i;
                cnt <= 2'd1;
                first_pend <= !in_msg;
                in_msg <= 1'b1;
            end else if (cnt == 2'd1 && timestamp_enable_i) begin
                hi <= raw_byte_i;
                cnt <= 2'd2;
            end else if (cnt == 2'd1) begin
                cnt <= 2'd0;
                first_pend <= 1'b0;
            end else begin
                lo <= raw_byte_i;
                cnt <= 2'd1;
                first_pend <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            evt_valid_o <= 1'b0;
            first_monitor_byte_o <= 8'h00;
            second_monitor_byte_o <= 8'h00;
            evt_flags_o <= 4'h0;
        end else if (load) begin
            evt_valid_o <= 1'b1;
            if (fire_end) begin
                first_monitor_byte_o <= (cnt == 2'd0) ? MQ_FILL_BYTE : lo;
                second_monitor_byte_o <= end_hi;
                evt_flags_o <= end_flags;
            end else if (vstar_mode_i) begin
                first_monitor_byte_o <= raw_byte_i; // RULE12
                second_monitor_byte_o <= MQ_FILL_BYTE; // RULE13
                evt_flags_o <= MQ_VSTAR_FLAGS; // RULE11
            end else begin
                first_monitor_byte_o <= lo; // RULE12
                second_monitor_byte_o <= pair_hi; // RULE13
                evt_flags_o <= {1'b0, 1'b0, first_pend, 1'b0}; // RULE8 RULE10
            end
        end else if (evt_ready_i) begin
            evt_valid_o <= 1'b0;
        end
    end

    property p_vstar_fill;
        @(posedge clk_i) disable iff (!rst_n_i)
        load && vstar_mode_i && !fire_end |=> second_monitor_byte_o == MQ_FILL_BYTE && evt_flags_o == 4'hB;
    endproperty
    a_vstar_fill: assert property (p_vstar_fill) else $error("single-read event not filled"); // RULE13

    property p_gci_twice;
        @(posedge clk_i) disable iff (!rst_n_i)
        acc && !vstar_mode_i |-> have_prev && raw_byte_i == prev_raw;
    endproperty
    a_gci_twice: assert property (p_gci_twice) else $error("byte accepted without repeat"); // RULE12
endmodule
`default_nettype wire

//--- hdl/mq_event_writer.sv
`timescale 1ns/1ns
`default_nettype none
// Function
// RULE1 - untimed entry: status word then data word
// RULE2 - queue length comes from size register
// RULE3 - read new-status flag before writing entry
// RULE4 - flag clear: write bytes, then status flagged
// RULE5 - flag set: raise queue overflow flag
// RULE6 - port select bit: 0 port0, 1 port1
// RULE7 - untimed last flag uses odd for placement
// RULE8 - first flag marks word with first byte
// RULE9 - abort flag set for aborted message
// RULE10 - odd flag: one byte one, two zero
// RULE11 - V* mode flags fixed 1,0,1,1
// RULE12 - low byte: twice-seen byte, V* once
// RULE13 - high byte: next byte, V* all ones
// RULE14 - timed entry: status, data, stamp, zero
// RULE15 - stamp holds counter at event time
// RULE16 - timed last flag: next word has last
// RULE17 - processor clears new-status to acknowledge
// RULE18 - channel field names one of eight
// RULE19 - advance position, wrap at queue size
module mq_event_writer (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // configuration
    input wire logic vstar_mode_i,
    input wire logic timestamp_enable_i,
    input wire logic [mq_pkg::MQ_ADDR_W-1:0] queue_base_i,
    input wire logic [mq_pkg::MQ_IDX_W-1:0] queue_size_reg_i,
    // monitor receivers, same clock
    input wire logic line_port_select_i,
    input wire logic [2:0] channel_index_i,
    input wire logic raw_valid_i,
    input wire logic [7:0] raw_byte_i,
    input wire logic eom_i,
    input wire logic abort_i,
    // shared memory
    output logic mem_req_o,
    output logic mem_we_o,
    output logic [mq_pkg::MQ_ADDR_W-1:0] mem_addr_o,
    output logic [15:0] mem_wdata_o,
    input wire logic mem_ack_i,
    input wire logic [15:0] mem_rdata_i,
    // status
    output logic queue_overflow_flag_o,
    output logic busy_o,
    output logic [mq_pkg::MQ_IDX_W-1:0] write_index_o
);
    import mq_pkg::*;

    mq_state_t state, next_state;
    logic evt_valid;
    logic evt_take;
    logic [7:0] b_lo, b_hi;
    logic [3:0] b_flags;
    logic [MQ_TS_W-1:0] stamp_now;
    logic [15:0] cap_status, cap_data;
    logic [MQ_TS_W-1:0] cap_stamp;
    logic cap_ts;
    logic [MQ_IDX_W-1:0] idx;
    logic [1:0] word_off;

    function automatic logic [MQ_ADDR_W-1:0] entry_addr(input logic [MQ_ADDR_W-1:0] base,
                                                        input logic [MQ_IDX_W-1:0] index,
                                                        input logic ts, input logic [1:0] off);
        logic [MQ_ADDR_W-1:0] ofs;
        ofs = ts ? MQ_ADDR_W'({index, 2'b00}) : MQ_ADDR_W'({index, 1'b0});
        entry_addr = base + ofs + MQ_ADDR_W'(off);
    endfunction

    // ========================================
    // byte assembly and time base
    mq_byte_pair u_pair (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .vstar_mode_i(vstar_mode_i),
        .timestamp_enable_i(timestamp_enable_i),
        .raw_valid_i(raw_valid_i),
        .raw_byte_i(raw_byte_i),
        .eom_i(eom_i),
        .abort_i(abort_i),
        .evt_ready_i(evt_take),
        .evt_valid_o(evt_valid),
        .first_monitor_byte_o(b_lo),
        .second_monitor_byte_o(b_hi),
        .evt_flags_o(b_flags)
    );

    mq_stamp_counter #(
        .TICK_DIV(MQ_TICK_DIV)
    ) u_stamp (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .stamp_o(stamp_now)
    );

    // ========================================
    // decode
    assign evt_take = (state == MQ_IDLE) && evt_valid;
    wire ns_busy = mem_rdata_i[MQ_NS_BIT];
    wire last_slot = (idx >= queue_size_reg_i - 16'h0001) || (queue_size_reg_i == 16'h0000);
    wire [MQ_IDX_W-1:0] idx_inc = last_slot ? MQ_IDX_RESET : idx + 16'h0001;
    wire [15:0] new_status = {1'b0, 3'b000, line_port_select_i, channel_index_i, 4'h0, b_flags};

    always_comb begin
        next_state = state;
        case (state)
            MQ_IDLE: begin
                if (evt_valid) begin
                    next_state = MQ_READ;
                end
            end
            MQ_READ: begin
                if (mem_ack_i) begin
                    next_state = ns_busy ? MQ_OVF : MQ_DATA; // RULE3 RULE5
                end
            end
            MQ_DATA: begin
                if (mem_ack_i) begin
                    next_state = cap_ts ? MQ_STAMP : MQ_STATUS; // RULE1 RULE14
                end
            end
            MQ_STAMP: begin
                if (mem_ack_i) begin
                    next_state = MQ_ZERO;
                end
            end
            MQ_ZERO: begin
                if (mem_ack_i) begin
                    next_state = MQ_STATUS;
                end
            end
            MQ_STATUS: begin
                if (mem_ack_i) begin
                    next_state = MQ_IDLE;
                end
            end
            MQ_OVF: next_state = MQ_IDLE;
            default: next_state = MQ_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= MQ_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ========================================
    // event capture; the stamp is caught when the event reaches the writer
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cap_status <= 16'h0000;
            cap_data <= 16'h0000;
            cap_stamp <= MQ_TS_RESET;
            cap_ts <= 1'b0;
        end else if (evt_take) begin
            cap_status <= new_status; // RULE6 RULE18 RULE7 RULE9 RULE16
            cap_data <= {b_hi, b_lo};
            cap_stamp <= stamp_now; // RULE15
            cap_ts <= timestamp_enable_i;
        end
    end

    // ========================================
    // queue position; a refused entry is dropped and keeps its slot, so the next entry lands there
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            idx <= MQ_IDX_RESET;
        end else if (state == MQ_STATUS && mem_ack_i) begin
            idx <= idx_inc; // RULE2 RULE19
        end
    end

    // ========================================
    // memory port
    always_comb begin
        case (state)
            MQ_DATA: word_off = MQ_OFF_DATA;
            MQ_STAMP: word_off = MQ_OFF_STAMP;
            MQ_ZERO: word_off = MQ_OFF_ZERO;
            default: word_off = MQ_OFF_STATUS;
        endcase
    end

    always_comb begin
        case (state)
            MQ_DATA: mem_wdata_o = cap_data;
            MQ_STAMP: mem_wdata_o = cap_stamp;
            MQ_ZERO: mem_wdata_o = MQ_ZERO_WORD; // RULE14
            MQ_STATUS: mem_wdata_o = cap_status | 16'h8000; // RULE4
            default: mem_wdata_o = 16'h0000;
        endcase
    end

    assign mem_req_o = (state != MQ_IDLE) && (state != MQ_OVF);
    assign mem_we_o = mem_req_o && (state != MQ_READ);
    assign mem_addr_o = entry_addr(queue_base_i, idx, cap_ts, word_off);
    assign queue_overflow_flag_o = (state == MQ_OVF); // RULE5
    assign busy_o = (state != MQ_IDLE);
    assign write_index_o = idx;

    // ========================================
    // checks
    // slot start worked out by multiplication, apart from the shifts in entry_addr
    wire [MQ_ADDR_W-1:0] chk_base = queue_base_i + MQ_ADDR_W'(idx) * (cap_ts ? 24'h4 : 24'h2);

    property p_status_flag;
        @(posedge clk_i) disable iff (!rst_n_i)
        mem_we_o && state == MQ_STATUS |-> mem_wdata_o[MQ_NS_BIT]
            && mem_addr_o == chk_base;
    endproperty
    a_status_flag: assert property (p_status_flag) else $error("status written without new-status"); // RULE4

    property p_read_first;
        @(posedge clk_i) disable iff (!rst_n_i)
        $rose(mem_we_o) |-> $past(state) == MQ_READ && $past(mem_ack_i) && !$past(ns_busy);
    endproperty
    a_read_first: assert property (p_read_first) else $error("write without prior flag read"); // RULE3

    property p_overflow;
        @(posedge clk_i) disable iff (!rst_n_i)
        state == MQ_READ && mem_ack_i && ns_busy |=> queue_overflow_flag_o ##1 !queue_overflow_flag_o && !mem_req_o;
    endproperty
    a_overflow: assert property (p_overflow) else $error("occupied slot not flagged"); // RULE5

    property p_zero_word;
        @(posedge clk_i) disable iff (!rst_n_i)
        mem_we_o && word_off == MQ_OFF_ZERO |-> mem_wdata_o == 16'h0000 && cap_ts;
    endproperty
    a_zero_word: assert property (p_zero_word) else $error("bad padding word"); // RULE14

    property p_stamp_word;
        @(posedge clk_i) disable iff (!rst_n_i)
        evt_take && timestamp_enable_i |=> cap_stamp == $past(stamp_now)
            ##[1:1000] (state == MQ_STAMP || state == MQ_OVF);
    endproperty
    a_stamp_word: assert property (p_stamp_word) else $error("stamp not captured"); // RULE15

    property p_wrap;
        @(posedge clk_i) disable iff (!rst_n_i)
        state == MQ_STATUS && mem_ack_i && idx == queue_size_reg_i - 16'h0001 |=> idx == 16'h0000;
    endproperty
    a_wrap: assert property (p_wrap) else $error("queue index did not wrap"); // RULE19

    property p_port_bit;
        @(posedge clk_i) disable iff (!rst_n_i)
        evt_take |=> cap_status[MQ_PORT_BIT] == $past(line_port_select_i)
            && cap_status[10:8] == $past(channel_index_i);
    endproperty
    a_port_bit: assert property (p_port_bit) else $error("port or channel field wrong"); // RULE6

    property p_plain_len;
        @(posedge clk_i) disable iff (!rst_n_i)
        state == MQ_DATA && mem_ack_i && !cap_ts |=> state == MQ_STATUS;
    endproperty
    a_plain_len: assert property (p_plain_len) else $error("untimed entry too long"); // RULE1

    property p_req_hold;
        @(posedge clk_i) disable iff (!rst_n_i)
        mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_we_o) && $stable(mem_addr_o) && $stable(mem_wdata_o);
    endproperty
    a_req_hold: assert property (p_req_hold) else $error("access changed before acknowledge"); // RULE4

    property p_read_addr;
        @(posedge clk_i) disable iff (!rst_n_i)
        mem_req_o && !mem_we_o |-> mem_addr_o == chk_base;
    endproperty
    a_read_addr: assert property (p_read_addr) else $error("flag read from wrong slot"); // RULE3

    property p_data_first;
        @(posedge clk_i) disable iff (!rst_n_i)
        $rose(mem_we_o) |-> mem_addr_o == chk_base + 24'h1 && mem_wdata_o == cap_data;
    endproperty
    a_data_first: assert property (p_data_first) else $error("entry not opened with data word"); // RULE4

    property p_status_last;
        @(posedge clk_i) disable iff (!rst_n_i)
        state == MQ_STATUS && mem_ack_i |=> !mem_req_o && !busy_o;
    endproperty
    a_status_last: assert property (p_status_last) else $error("status word not written last"); // RULE4

    property p_ovf_quiet;
        @(posedge clk_i) disable iff (!rst_n_i)
        queue_overflow_flag_o |-> !mem_req_o && $past(state) == MQ_READ && $past(ns_busy);
    endproperty
    a_ovf_quiet: assert property (p_ovf_quiet) else $error("overflow without occupied slot"); // RULE5

    property p_idx_range;
        @(posedge clk_i) disable iff (!rst_n_i)
        state == MQ_STATUS && mem_ack_i |=> idx < queue_size_reg_i || queue_size_reg_i == 16'h0000;
    endproperty
    a_idx_range: assert property (p_idx_range) else $error("queue index past configured size"); // RULE2

    property p_timed_len;
        @(posedge clk_i) disable iff (!rst_n_i)
        state == MQ_DATA && mem_ack_i && cap_ts |=> state == MQ_STAMP;
    endproperty
    a_timed_len: assert property (p_timed_len) else $error("timed entry lost its stamp word"); // RULE14

    property p_stamp_slot;
        @(posedge clk_i) disable iff (!rst_n_i)
        state == MQ_STAMP && mem_we_o |-> mem_addr_o == chk_base + 24'h2 && mem_wdata_o == cap_stamp && cap_ts;
    endproperty
    a_stamp_slot: assert property (p_stamp_slot) else $error("time stamp word misplaced"); // RULE14
endmodule
`default_nettype wire

//--- tb/mq_mem_model.sv
`timescale 1ns/1ns
`default_nettype none
module mq_mem_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // access port
    input wire logic req_i,
    input wire logic we_i,
    input wire logic [23:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic [1:0] lat_i,
    output logic ack_o,
    output logic [15:0] rdata_o
);
    logic [15:0] words [0:255];
    logic [1:0] waited;
    logic [15:0] junk;
    // ========================================
    // answer
    // zero latency acks in the request's own cycle
    assign ack_o = req_i && (waited >= lat_i);
    // read data only means something with ack; a flipping pattern otherwise
    assign rdata_o = ack_o ? words[addr_i[7:0]] : junk;
    // plain always: the processor side also writes the array
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            waited <= 2'h0;
            junk <= 16'h5AA5;
        end else begin
            junk <= ~junk;
            waited <= (req_i && !ack_o) ? waited + 2'h1 : 2'h0;
            if (req_i && ack_o && we_i) begin
                words[addr_i[7:0]] <= wdata_i;
            end
        end
    end
endmodule
`default_nettype wire

//--- tb/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
    import mq_pkg::*;
    localparam logic [23:0] BASE = 24'h000010;
    logic [15:0] qsize = 16'h0003;
    typedef struct packed {logic t; logic p; logic [2:0] c; logic [7:0] b; logic [1:0] l;} mq_row_t;
    mq_row_t rows [6] = '{'{1'b0, 1'b0, 3'h0, 8'h3C, 2'h0}, '{1'b0, 1'b1, 3'h7, 8'hC3, 2'h2},
        '{1'b1, 1'b1, 3'h5, 8'h00, 2'h1}, '{1'b1, 1'b0, 3'h2, 8'hFF, 2'h1},
        '{1'b0, 1'b0, 3'h3, 8'h81, 2'h3}, '{1'b0, 1'b1, 3'h6, 8'h7E, 2'h0}};
    logic clk = 1'b0, rst_n = 1'b0, vstar = 1'b1, ts_en = 1'b0, port = 1'b0;
    logic [2:0] ch = 3'h0;
    logic raw_valid = 1'b0, eom = 1'b0, abort = 1'b0;
    logic [7:0] raw_byte = 8'h00;
    logic [1:0] lat = 2'h0;
    logic mem_req, mem_we, mem_ack, ovf, busy;
    logic [23:0] mem_addr, last_wa;
    logic [15:0] mem_wdata, mem_rdata, widx, exp_idx = 16'h0000, stamp, prev_stamp;
    int n_errors = 0, compares = 0, cyc = 0, t_rd = 0, prev_t = 0, wr_cnt = 0, n_ovf = 0;
    bit have_prev = 0;
    mq_event_writer uut (.clk_i(clk), .rst_n_i(rst_n), .vstar_mode_i(vstar), .timestamp_enable_i(ts_en),
        .queue_base_i(BASE), .queue_size_reg_i(qsize), .line_port_select_i(port), .channel_index_i(ch),
        .raw_valid_i(raw_valid), .raw_byte_i(raw_byte), .eom_i(eom), .abort_i(abort), .mem_req_o(mem_req),
        .mem_we_o(mem_we), .mem_addr_o(mem_addr), .mem_wdata_o(mem_wdata), .mem_ack_i(mem_ack),
        .mem_rdata_i(mem_rdata), .queue_overflow_flag_o(ovf), .busy_o(busy), .write_index_o(widx));
    mq_mem_model mem (.clk_i(clk), .rst_n_i(rst_n), .req_i(mem_req), .we_i(mem_we), .addr_i(mem_addr),
        .wdata_i(mem_wdata), .lat_i(lat), .ack_o(mem_ack), .rdata_o(mem_rdata));
    always #50 clk = ~clk;
    // ========================================
    // watchers and hang cut-off
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (mem_req && mem_ack && !mem_we) t_rd <= cyc;
        if (mem_req === 1'b1 && mem_ack && mem_we === 1'b1) begin
            wr_cnt <= wr_cnt + 1;
            last_wa <= mem_addr;
        end
        if (ovf === 1'b1) n_ovf <= n_ovf + 1;
        if (cyc == 20000) begin
            n_errors++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    function automatic logic [7:0] slot(input logic t);
        return 8'(BASE + 24'(exp_idx) * (t ? 24'h4 : 24'h2));
    endfunction
    // ========================================
    // stimulus and entry checks
    task automatic send(input logic [7:0] b, input logic e, input logic a);
        @(posedge clk);
        raw_valid <= !(e || a);
        raw_byte <= b;
        eom <= e;
        abort <= a;
        @(posedge clk);
        raw_valid <= 1'b0;
        eom <= 1'b0;
        abort <= 1'b0;
        repeat (3) @(posedge clk);
        while (busy === 1'b1) @(posedge clk);
    endtask
    // junk with the new-status bit clear, so a missed write shows
    task automatic prep(input logic t);
        logic [7:0] a;
        a = slot(t);
        for (int k = 0; k < 4; k++) mem.words[a + 8'(k)] = 16'h7E7E;
        wr_cnt = 0;
    endtask
    task automatic entry(input logic [15:0] st, input logic [15:0] dat, input logic [15:0] msk, input logic t);
        logic [7:0] a;
        a = slot(t);
        check("status word", mem.words[a], st);
        check("data word", mem.words[a + 8'h1] & msk, dat);
        check("write count", 16'(wr_cnt), t ? 16'h4 : 16'h2);
        check("last write address", 16'(last_wa), 16'(BASE) + 16'(a - 8'(BASE)));
        if (t) begin
            check("zero word", mem.words[a + 8'h3], MQ_ZERO_WORD);
            stamp = mem.words[a + 8'h2];
        end
        mem.words[a][15] = 1'b0;
        exp_idx = (exp_idx == qsize - 16'h1) ? 16'h0000 : exp_idx + 16'h1;
        check("write index", widx, exp_idx);
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            @(posedge clk);
            ts_en <= rows[i].t;
            port <= rows[i].p;
            ch <= rows[i].c;
            lat <= rows[i].l;
            @(posedge clk);
            prep(rows[i].t);
            send(rows[i].b, 1'b0, 1'b0);
            entry({1'b1, 3'h0, rows[i].p, rows[i].c, 4'h0, MQ_VSTAR_FLAGS}, {MQ_FILL_BYTE, rows[i].b},
                16'hFFFF, rows[i].t);
            if (rows[i].t) begin
                if (have_prev) check("stamp step", stamp - prev_stamp, 16'(t_rd - prev_t));
                have_prev = 1;
                prev_stamp = stamp;
                prev_t = t_rd;
            end
        end
        // occupied slot: no write, one overflow pulse, index kept
        prep(1'b0);
        mem.words[slot(1'b0)][15] = 1'b1;
        send(8'h99, 1'b0, 1'b0);
        check("overflow pulses", 16'(n_ovf), 16'h1);
        check("writes on overflow", 16'(wr_cnt), 16'h0);
        check("data kept", mem.words[slot(1'b0) + 8'h1], 16'h7E7E);
        check("index kept", widx, exp_idx);
        // second reset mid-run
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        check("index in reset", widx, 16'h0000);
        check("req in reset", {15'h0, mem_req}, 16'h0000);
        rst_n <= 1'b1;
        exp_idx = 16'h0000;
        vstar <= 1'b0;
        ts_en <= 1'b0;
        port <= 1'b1;
        ch <= 3'h4;
        lat <= 2'h1;
        qsize <= 16'h0002;
        prep(1'b0);
        send(8'hAB, 1'b0, 1'b0);
        send(8'hAB, 1'b0, 1'b0);
        send(8'hCD, 1'b0, 1'b0);
        send(8'hCD, 1'b0, 1'b0);
        entry(16'h8C02, 16'hCDAB, 16'hFFFF, 1'b0);
        prep(1'b0);
        send(8'h00, 1'b1, 1'b0);
        entry(16'h8C01, 16'hFFFF, 16'hFFFF, 1'b0);
        prep(1'b0);
        send(8'hEE, 1'b0, 1'b0);
        send(8'hEE, 1'b0, 1'b0);
        send(8'h00, 1'b1, 1'b0);
        entry(16'h8C0B, 16'h00EE, 16'h00FF, 1'b0);
        prep(1'b0);
        send(8'h11, 1'b0, 1'b0);
        send(8'h11, 1'b0, 1'b0);
        send(8'h00, 1'b0, 1'b1);
        entry(16'h8C0E, 16'h0011, 16'h00FF, 1'b0);
        ts_en <= 1'b1;
        prep(1'b1);
        send(8'h21, 1'b0, 1'b0);
        send(8'h21, 1'b0, 1'b0);
        send(8'h43, 1'b0, 1'b0);
        send(8'h43, 1'b0, 1'b0);
        send(8'h00, 1'b1, 1'b0);
        entry(16'h8C03, 16'h4321, 16'hFFFF, 1'b1);
        tally_and_finish();
    end
endmodule
`default_nettype wire
